/* File: hw/xnor_chain_board_test.v */
/*
  board connectivity test mode: entry and exit on the release of the platform reset,
  parity of all chained pins onto the fan speed sense pin while the mode is active.
  assumes pin levels arrive asynchronously and that power-on reset is a synchronous
  pulse on srst in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "board_test_consts.vh"

module xnor_chain_board_test (
  input wire clk,
  input wire srst,
  input wire platform_reset_n,
  input wire lpc_frame_n,
  input wire lpc_lad0,
  input wire [`CHAIN_WIDTH-1:`CHAIN_OTHER_LSB] chain_pins,
  input wire normal_fan_out,
  input wire normal_fan_oe,
  output reg test_mode,
  output reg functions_enabled,
  output reg fan_speed_sense_out,
  output reg fan_speed_sense_oe
);

  // ==========================================================
  // input synchronisers
  // every pin level is asynchronous to clk and passes two flops before use
  reg [1:0] rst_sync_q;
  reg [`CHAIN_WIDTH-1:0] pin_meta_q;
  reg [`CHAIN_WIDTH-1:0] pin_sync_q;
  wire [`CHAIN_WIDTH-1:0] pin_raw;
  wire plat_rst_level;
  wire frame_level;
  wire lad0_level;

  // platform reset is kept out of this vector, so it never feeds the chain
  assign pin_raw = {chain_pins, lpc_lad0, lpc_frame_n};

  always @(posedge clk) begin
    if (srst) begin
      // released level: a pin already high after power-on is no rise
      rst_sync_q <= {2{`PLAT_RST_SYNC_RESET}};
    end else begin
      rst_sync_q <= {rst_sync_q[0], platform_reset_n};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      pin_meta_q <= {`CHAIN_WIDTH{`SYNC_RESET}};
      pin_sync_q <= {`CHAIN_WIDTH{`SYNC_RESET}};
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // only the second stage is read; the first may still be settling
  assign plat_rst_level = rst_sync_q[1];
  assign frame_level = pin_sync_q[`CHAIN_FRAME_BIT];
  assign lad0_level = pin_sync_q[`CHAIN_LAD0_BIT];

  // ==========================================================
  // strap decode
  // straps pass the same two flop stages as the reset level, so
  // both line up in the cycle in which the release is seen
  wire enter_req;

  assign enter_req = ~frame_level & ~lad0_level;

  // ==========================================================
  // mode state machine
  // the low phase of the platform reset is held in the state, so only a
  // real low-to-high release can move the mode
  localparam [1:0] ST_NORMAL = 2'h0;
  localparam [1:0] ST_NORMAL_HELD = 2'h1;
  localparam [1:0] ST_TEST = 2'h2;
  localparam [1:0] ST_TEST_HELD = 2'h3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  wire mode_active;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (~plat_rst_level) begin
          state_d = ST_NORMAL_HELD;
        end
      end
      ST_NORMAL_HELD: begin
        if (plat_rst_level) begin
          if (enter_req) begin
            state_d = ST_TEST;
          end else begin
            state_d = ST_NORMAL;
          end
        end
      end
      ST_TEST: begin
        // straps are plain chain inputs here; their levels cannot move the mode
        if (~plat_rst_level) begin
          state_d = ST_TEST_HELD;
        end
      end
      ST_TEST_HELD: begin
        if (plat_rst_level) begin
          if (enter_req) begin
            state_d = ST_TEST;
          end else begin
            state_d = ST_NORMAL;
          end
        end
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      // power-on leaves the test mode whatever the straps show
      state_q <= `MODE_STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign mode_active = (state_q == ST_TEST) | (state_q == ST_TEST_HELD);

  // ==========================================================
  // parity chain
  // three equal banks plus the two straps; a shallow tree per bank keeps the
  // path from the synchronisers to the output flop short
  wire strap_parity;
  wire bank0_parity;
  wire bank1_parity;
  wire bank2_parity;
  wire chain_parity;

  parity_reduce #(
    .WIDTH(`CHAIN_STRAP_WIDTH)
  ) u_parity_strap (
    .bits(pin_sync_q[`CHAIN_LAD0_BIT:`CHAIN_FRAME_BIT]),
    .parity(strap_parity)
  );

  parity_reduce #(
    .WIDTH(`CHAIN_BANK_WIDTH)
  ) u_parity_bank0 (
    .bits(pin_sync_q[`CHAIN_BANK0_LSB+`CHAIN_BANK_WIDTH-1:`CHAIN_BANK0_LSB]),
    .parity(bank0_parity)
  );

  parity_reduce #(
    .WIDTH(`CHAIN_BANK_WIDTH)
  ) u_parity_bank1 (
    .bits(pin_sync_q[`CHAIN_BANK1_LSB+`CHAIN_BANK_WIDTH-1:`CHAIN_BANK1_LSB]),
    .parity(bank1_parity)
  );

  parity_reduce #(
    .WIDTH(`CHAIN_BANK_WIDTH)
  ) u_parity_bank2 (
    .bits(pin_sync_q[`CHAIN_BANK2_LSB+`CHAIN_BANK_WIDTH-1:`CHAIN_BANK2_LSB]),
    .parity(bank2_parity)
  );

  assign chain_parity = strap_parity ^ bank0_parity ^ bank1_parity ^ bank2_parity;

  // ==========================================================
  // pin steering
  reg fan_out_d;
  reg fan_oe_d;

  always @* begin
    fan_out_d = `CHAIN_OUT_RESET;
    fan_oe_d = 1'h0;
    if (mode_active) begin
      // the tach pin turns into the chain output and is driven
      fan_out_d = chain_parity;
      fan_oe_d = 1'h1;
    end else begin
      // normal tach input: the chain no longer reaches the pin
      fan_out_d = normal_fan_out & normal_fan_oe;
      fan_oe_d = normal_fan_oe;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      test_mode <= `TEST_MODE_RESET;
      functions_enabled <= 1'h0;
    end else begin
      test_mode <= mode_active;
      functions_enabled <= ~mode_active;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      fan_speed_sense_out <= `CHAIN_OUT_RESET;
      fan_speed_sense_oe <= 1'h0;
    end else begin
      fan_speed_sense_out <= fan_out_d;
      fan_speed_sense_oe <= fan_oe_d;
    end
  end

endmodule

`default_nettype wire

/* File: hw/board_test_consts.vh */
/*
  constants for the board connectivity test chain.
  assumes nothing beyond a verilog-2005 compiler; included by bare name.
*/
`ifndef BOARD_TEST_CONSTS_VH
`define BOARD_TEST_CONSTS_VH

// ==========================================================
// chain geometry
`define CHAIN_WIDTH 89
`define CHAIN_FRAME_BIT 0
`define CHAIN_LAD0_BIT 1
`define CHAIN_OTHER_LSB 2
`define CHAIN_STRAP_WIDTH 2
`define CHAIN_BANK_WIDTH 29
`define CHAIN_BANK0_LSB 2
`define CHAIN_BANK1_LSB 31
`define CHAIN_BANK2_LSB 60

// ==========================================================
// reset values
`define TEST_MODE_RESET 1'b0
`define SYNC_RESET 1'b0
`define CHAIN_OUT_RESET 1'b0
`define PLAT_RST_SYNC_RESET 1'h1
`define MODE_STATE_RESET 2'h0

`endif

/* File: hw/parity_reduce.v */
/*
  parameterised xor reduction of a vector of chained pin levels.
  assumes inputs are already synchronous to whatever consumes the result.
*/
`timescale 1ns/1ps
`default_nettype none

module parity_reduce #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] bits,
  output wire parity
);

  assign parity = ^bits;

endmodule

`default_nettype wire

/* File: verification/chain_chk_sva.sv */
/* checker on the chain top ports.
   assumes one clk domain with srst. */
`timescale 1ns/1ps
`default_nettype none
module chain_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic platform_reset_n,
  input wire logic lpc_frame_n,
  input wire logic lpc_lad0,
  input wire logic [88:2] chain_pins,
  input wire logic normal_fan_out,
  input wire logic normal_fan_oe,
  input wire logic test_mode,
  input wire logic functions_enabled,
  input wire logic fan_speed_sense_out,
  input wire logic fan_speed_sense_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_mode_enter: assert property ($rose(platform_reset_n) && !lpc_frame_n && !lpc_lad0 |-> ##[4:6] test_mode)
    else $error("no entry");
  a_mode_exit: assert property ($rose(platform_reset_n) && (lpc_frame_n || lpc_lad0) |-> ##[4:6] !test_mode)
    else $error("no exit");
  a_mode_held: assert property ($changed(test_mode) |-> $past(platform_reset_n, 3)) else $error("mode moved");
  a_por_exit: assert property (disable iff (1'b0) srst |=> !test_mode) else $error("mode kept");
  a_pins_cut: assert property (test_mode && $past(test_mode) |-> fan_speed_sense_oe && !functions_enabled)
    else $error("pins not cut");
  a_chain_parity: assert property (test_mode && $past(test_mode, 4) |-> fan_speed_sense_out ==
    ^{$past(chain_pins, 3), $past(lpc_lad0, 3), $past(lpc_frame_n, 3)}) else $error("bad parity");
  a_normal_pin: assert property (!test_mode && !$past(test_mode) && !$past(srst) |->
    fan_speed_sense_out == $past(normal_fan_out && normal_fan_oe)) else $error("pin moved");
  a_funcs_back: assert property (!test_mode && !$past(test_mode) && !$past(srst) |-> functions_enabled)
    else $error("functions cut");
  a_por_quiet: assert property ($fell(srst) |-> !test_mode [*5]) else $error("mode after power-on");
  a_normal_oe: assert property (!test_mode && !$past(test_mode) && !$past(srst) |->
    fan_speed_sense_oe == $past(normal_fan_oe)) else $error("pin drive moved");
endmodule
bind xnor_chain_board_test chain_chk u_chk (
  .clk(clk),
  .srst(srst),
  .platform_reset_n(platform_reset_n),
  .lpc_frame_n(lpc_frame_n),
  .lpc_lad0(lpc_lad0),
  .chain_pins(chain_pins),
  .normal_fan_out(normal_fan_out),
  .normal_fan_oe(normal_fan_oe),
  .test_mode(test_mode),
  .functions_enabled(functions_enabled),
  .fan_speed_sense_out(fan_speed_sense_out),
  .fan_speed_sense_oe(fan_speed_sense_oe)
);
`default_nettype wire

/* File: verification/board_tester.sv */
/* tester model driving every chained pin and the platform reset.
   assumes tasks are called just after a clk edge. */
`timescale 1ns/1ps
`default_nettype none
module board_tester(input wire logic clk, output logic platform_reset_n, output logic lpc_frame_n,
  output logic lpc_lad0, output logic [88:2] chain_pins);
  logic [88:0] p = '0;
  initial platform_reset_n = 1'b0;
  assign {chain_pins, lpc_lad0, lpc_frame_n} = p;
  task automatic set(input int k, input logic v);
    @(posedge clk); #2 p[k] = v; repeat (4) @(posedge clk); #2;
  endtask
  // levels settle long before the rise so the synced copies agree
  task automatic pulse(input logic f, input logic l);
    p[1:0] = {l, f}; repeat (4) @(posedge clk); #2 platform_reset_n = 1'b0;
    repeat (4) @(posedge clk); #2 platform_reset_n = 1'b1;
    repeat (8) @(posedge clk); #2;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
/* bench: entry, parity walk both ways, both exits, power-on exit.
   assumes tester model and checker compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, srst = 1'b1, normal_fan_out = 1'b0, normal_fan_oe = 1'b0, e;
  logic platform_reset_n, lpc_frame_n, lpc_lad0, test_mode, functions_enabled, fan_speed_sense_out;
  logic fan_speed_sense_oe;
  logic [88:2] chain_pins;
  int err_count = 0, n_checks = 0;
  board_tester u_tester (
    .clk(clk),
    .platform_reset_n(platform_reset_n),
    .lpc_frame_n(lpc_frame_n),
    .lpc_lad0(lpc_lad0),
    .chain_pins(chain_pins)
  );
  xnor_chain_board_test u_xnor_chain_board_test (
    .clk(clk),
    .srst(srst),
    .platform_reset_n(platform_reset_n),
    .lpc_frame_n(lpc_frame_n),
    .lpc_lad0(lpc_lad0),
    .chain_pins(chain_pins),
    .normal_fan_out(normal_fan_out),
    .normal_fan_oe(normal_fan_oe),
    .test_mode(test_mode),
    .functions_enabled(functions_enabled),
    .fan_speed_sense_out(fan_speed_sense_out),
    .fan_speed_sense_oe(fan_speed_sense_oe)
  );
  initial forever #12.5 clk = ~clk;
  initial begin
    #200us; err_count++; wrap_up;
  end
  task automatic chk(input logic s, input logic x);
    n_checks++;
    if (s !== x) begin err_count++; $display("mismatch %0t wrong level", $time); end
  endtask
  task automatic enter;
    u_tester.pulse(1'b0, 1'b0);
    chk(test_mode, 1'b1);
    chk(functions_enabled, 1'b0);
    chk(fan_speed_sense_oe, 1'b1);
    chk(fan_speed_sense_out, 1'b0);
    $display("enter done");
  endtask
  task automatic walk;
    e = 1'b0;
    for (int k = 88; k >= 0; k--) begin u_tester.set(k, 1'b1); e = ~e; chk(fan_speed_sense_out, e); end
    for (int k = 0; k < 89; k++) begin u_tester.set(k, 1'b0); e = ~e; chk(fan_speed_sense_out, e); end
    $display("walk done");
  endtask
  task automatic leave(input logic f, input logic l);
    u_tester.pulse(f, l);
    chk(test_mode, 1'b0);
    chk(functions_enabled, 1'b1);
    // pin follows the normal drive; toggling a former chain input must not show
    normal_fan_oe = 1'b1;
    normal_fan_out = 1'b1;
    u_tester.set(9, 1'b1);
    chk(fan_speed_sense_out, 1'b1);
    chk(fan_speed_sense_oe, 1'b1);
    normal_fan_out = 1'b0;
    u_tester.set(9, 1'b0);
    chk(fan_speed_sense_out, 1'b0);
    normal_fan_oe = 1'b0;
    normal_fan_out = 1'b1;
    u_tester.set(9, 1'b1);
    chk(fan_speed_sense_out, 1'b0);
    chk(fan_speed_sense_oe, 1'b0);
    u_tester.set(9, 1'b0);
    $display("exit done");
  endtask
  task automatic por;
    enter;
    @(posedge clk);
    #2 srst = 1'b1;
    @(posedge clk);
    #2 srst = 1'b0;
    @(posedge clk);
    #2;
    chk(test_mode, 1'b0);
    // straps still low and platform reset high: the mode must not come back
    repeat (8) @(posedge clk);
    #2;
    chk(test_mode, 1'b0);
    chk(functions_enabled, 1'b1);
    chk(fan_speed_sense_oe, 1'b0);
    $display("por done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED =="); else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk); #2 srst = 1'b0; @(posedge clk); #2;
    enter; walk; leave(1'b1, 1'b0); enter; leave(1'b0, 1'b1); por; wrap_up;
  end
endmodule
`default_nettype wire
